// [verilog/csd_pkg.sv]
// shared constants and types of the clock slew, status and diagnostic block
// assumes one 125 MHz system clock and a word-per-register software port
`default_nettype none

package csd_pkg;

    // ========================================================
    // register map
    localparam int          CSD_ADDR_W       = 8;
    localparam int          CSD_DATA_W       = 32;
    localparam logic [7:0]  SLEW_CTRL_OFS    = 8'h00;
    localparam logic [7:0]  READY_STAT_OFS   = 8'h04;
    localparam logic [7:0]  STOP_DIAG_OFS    = 8'h08;

    // ========================================================
    // field layout
    localparam int          STEP_CNT_LSB     = 24;
    localparam int          PDIV_LSB         = 16;
    localparam int          DEPTH_LSB        = 8;
    localparam int          UP_EN_BIT        = 2;
    localparam int          DN_EN_BIT        = 1;
    localparam int          BUSY_BIT         = 0;
    localparam int          STEP_CNT_W       = 4;
    localparam int          PDIV_W           = 4;
    localparam int          DEPTH_W          = 3;
    localparam int          READY_W          = 12;
    localparam int          STOP_W           = 7;
    localparam logic [STOP_W-1:0] STOP_RESET = 7'h00;

    // ========================================================
    // timing
    localparam int          STEP_HOLD_CYC    = 4;
    localparam logic [1:0]  HOLD_LAST        = 2'(STEP_HOLD_CYC - 1);

    // ========================================================
    // types
    typedef struct packed {
        logic [STEP_CNT_W-1:0] step_cnt;
        logic [DEPTH_W-1:0]    depth;
        logic                  up_en;
        logic                  dn_en;
    } csd_slew_cfg_s;

    typedef enum logic [1:0] {
        CSD_IDLE = 2'b00,
        CSD_SLEW = 2'b01
    } csd_seq_e;

    typedef struct packed {
        logic [7:0] div;
        logic       busy;
        logic       tick;
    } csd_slew_out_s;

    typedef struct packed {
        csd_seq_e              st;
        csd_slew_cfg_s         cfg;
        logic                  up;
        logic [1:0]            hold;
        logic [STEP_CNT_W-1:0] ticks;
        csd_slew_out_s         out;
    } csd_seq_state_s;

    typedef struct packed {
        csd_slew_cfg_s         pend_cfg;
        csd_slew_cfg_s         act_cfg;
        logic [PDIV_W-1:0]     pend_pdiv;
        logic [PDIV_W-1:0]     act_pdiv;
        logic [READY_W-1:0]    ready;
        logic [STOP_W-1:0]     stop;
        logic [CSD_DATA_W-1:0] rdata;
        logic                  loaded;
    } csd_top_state_s;

endpackage

`default_nettype wire

// [verilog/csd_slew_seq.sv]
// slew step sequencer: walks the divisor through powers of two
// assumes start is a one-cycle pulse carrying the settings to apply
`timescale 1ns/10ps
`default_nettype none

module csd_slew_seq
#(
    parameter int DIV_W = 8
)
(
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   start,
    input  wire logic                   up,
    input  wire csd_pkg::csd_slew_cfg_s cfg,
    output var csd_pkg::csd_slew_out_s  out
);
    import csd_pkg::*;

    if (DIV_W != 8)
    begin : g_bad_width
        $error("csd_slew_seq needs DIV_W of 8");
    end

    // ========================================================
    // helpers
    function automatic logic slew_allowed(input csd_slew_cfg_s c, input logic dir_up);
        slew_allowed = (c.depth != 3'h0) && (dir_up ? c.up_en : c.dn_en);
    endfunction

    function automatic logic [7:0] top_div(input logic [DEPTH_W-1:0] d);
        top_div = 8'h01 << d;
    endfunction

    // ========================================================
    // sequencer
    csd_seq_state_s s;
    csd_seq_state_s next_s;

    always_comb
    begin
        next_s = s;
        next_s.out.tick = 1'b0;
        case (s.st)
            CSD_IDLE:
            begin
                next_s.out.busy = 1'b0;
                next_s.out.div  = 8'h01;
            end
            CSD_SLEW:
            begin
                next_s.hold = s.hold + 2'h1;
                if (s.hold == HOLD_LAST)                                   // R4
                begin
                    next_s.hold     = 2'h0;
                    next_s.out.tick = 1'b1;
                    if (s.ticks == s.cfg.step_cnt)                         // R1
                    begin
                        next_s.ticks = 4'h0;
                        if (s.up ? (s.out.div == 8'h02)
                                 : (s.out.div == top_div(s.cfg.depth)))    // R2
                        begin
                            next_s.st       = CSD_IDLE;
                            next_s.out.busy = 1'b0;                        // R7
                            next_s.out.div  = 8'h01;
                        end
                        else if (s.up)
                        begin
                            next_s.out.div = s.out.div >> 1;               // R2
                        end
                        else
                        begin
                            next_s.out.div = s.out.div << 1;
                        end
                    end
                    else
                    begin
                        next_s.ticks = s.ticks + 4'h1;
                    end
                end
            end
            default:
            begin
                next_s.st = CSD_IDLE;
            end
        endcase
        if (start)
        begin
            next_s.cfg   = cfg;
            next_s.up    = up;
            next_s.hold  = 2'h0;
            next_s.ticks = 4'h0;
            if (slew_allowed(cfg, up))                                     // R5 R6
            begin
                next_s.st       = CSD_SLEW;
                next_s.out.busy = 1'b1;
                next_s.out.div  = up ? top_div(cfg.depth) : 8'h02;
            end
            else
            begin
                next_s.st       = CSD_IDLE;                                // R3 R17
                next_s.out.busy = 1'b0;
                next_s.out.div  = 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '{st: CSD_IDLE, cfg: '0, up: 1'b0, hold: 2'h0, ticks: 4'h0,
                   out: '{div: 8'h01, busy: 1'b0, tick: 1'b0}};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign out = s.out;

    // ========================================================
    // checks
    AST_NO_DEPTH_NO_SLEW: assert property (@(posedge clk) disable iff (!rst_n) // R3
        start && cfg.depth == 3'h0 |=> !out.busy && out.div == 8'h01)
        else $error("slew started with zero depth");
    AST_UP_START: assert property (@(posedge clk) disable iff (!rst_n) // R2
        start && up && cfg.up_en && cfg.depth != 3'h0
        |=> out.busy && out.div == (8'h01 << $past(cfg.depth)))
        else $error("upward slew did not start at the deepest divisor");
    AST_DIR_GATE: assert property (@(posedge clk) disable iff (!rst_n) // R5
        start && (up ? !cfg.up_en : !cfg.dn_en) |=> !out.busy)
        else $error("slew ran while its direction was disabled");
    AST_HOLD_SPACING: assert property (@(posedge clk) disable iff (!rst_n) // R4
        out.tick && !start |=> !out.tick [*3])
        else $error("step ticks closer than four clocks");
    AST_DIV_MOVES_ON_TICK: assert property (@(posedge clk) disable iff (!rst_n) // R1
        !$past(start) && $changed(out.div) |-> out.tick)
        else $error("divisor changed without a step tick");
    AST_IDLE_NO_DIV: assert property (@(posedge clk) disable iff (!rst_n) // R7
        !out.busy |-> out.div == 8'h01)
        else $error("divisor applied while not slewing");

endmodule

`default_nettype wire

// [verilog/csd_top.sv]
// clock slew controller with clock ready status and source stop controls
// assumes a single-cycle strobe register port, and that unlock and switch
// request come as levels and pulses from the system and oscillator blocks
//
// How it works
// R1: each slew step lasts step count plus one ticks
// R2: upward divisor starts at two to depth, halves; downward starts at two, doubles
// R3: depth zero means no intermediate divisor
// R4: each divisor tick spans four clocks
// R5: upward slewing only when up enable set
// R6: downward slewing only when down enable set
// R7: busy flag high only while slewing
// R8: new slew settings apply on switch request
// R9: writes refused while system is locked
// R10: slew reset values come from configuration straps
// R11: peripheral divisor field sits in bits 19:16
// R12: ready bits follow hardware stability, read-only
// R13: ready bit map, core clock at eleven
// R14: stop bit stops its clock source
// R15: stop bit map, all reset to zero
// R16: unimplemented bits read as zero
// R17: disabled direction switches directly, busy stays low
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module csd_top
#(
    parameter int ADDR_W = csd_pkg::CSD_ADDR_W
)
(
    input  wire logic                          SYS_CLK,
    input  wire logic                          RST_N,
    input  wire logic [ADDR_W-1:0]             ADDR,
    input  wire logic [csd_pkg::CSD_DATA_W-1:0] WDATA,
    input  wire logic                          WR,
    input  wire logic                          RD,
    output logic [csd_pkg::CSD_DATA_W-1:0]     RDATA,
    input  wire logic                          SYS_UNLOCKED,
    input  wire logic                          OSC_SWITCH_REQUEST,
    input  wire logic                          SWITCH_UPWARD,
    input  wire csd_pkg::csd_slew_cfg_s        CFG_SLEW,
    input  wire logic [csd_pkg::PDIV_W-1:0]    CFG_PERIPH_DIV,
    input  wire logic [csd_pkg::READY_W-1:0]   CLOCK_STABLE,
    output logic [csd_pkg::STOP_W-1:0]         SOURCE_STOP,
    output logic [csd_pkg::PDIV_W-1:0]         PERIPH_DIVISOR,
    output logic [7:0]                         SLEW_DIVISOR,
    output logic                               SLEW_BUSY,
    output logic                               SLEW_STEP_TICK
);
    import csd_pkg::*;

    if (ADDR_W < 4 || ADDR_W > 16)
    begin : g_bad_addr
        $error("csd_top needs ADDR_W between 4 and 16");
    end

    // ========================================================
    // address decode and register field packing helpers
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction

    function automatic logic [CSD_DATA_W-1:0] slew_word(input csd_slew_cfg_s c,
                                                      input logic [PDIV_W-1:0] pd,
                                                      input logic busy);
        logic [CSD_DATA_W-1:0] w;
        w = '0;                                                            // R16
        w[STEP_CNT_LSB +: STEP_CNT_W] = c.step_cnt;
        w[PDIV_LSB +: PDIV_W]         = pd;                                // R11
        w[DEPTH_LSB +: DEPTH_W]       = c.depth;
        w[UP_EN_BIT]                  = c.up_en;
        w[DN_EN_BIT]                  = c.dn_en;
        w[BUSY_BIT]                   = busy;                              // R7
        slew_word = w;
    endfunction

    function automatic csd_slew_cfg_s slew_fields(input logic [CSD_DATA_W-1:0] w);
        csd_slew_cfg_s c;
        c.step_cnt = w[STEP_CNT_LSB +: STEP_CNT_W];
        c.depth    = w[DEPTH_LSB +: DEPTH_W];
        c.up_en    = w[UP_EN_BIT];
        c.dn_en    = w[DN_EN_BIT];
        slew_fields = c;
    endfunction

    // ========================================================
    // slew sequencer
    csd_top_state_s s;
    csd_top_state_s next_s;
    csd_slew_out_s  seq_out;
    logic           seq_start;
    csd_slew_cfg_s  seq_cfg;

    // switch request hands the pending settings to the sequencer
    assign seq_start = OSC_SWITCH_REQUEST && s.loaded;                      // R8
    assign seq_cfg   = s.pend_cfg;

    csd_slew_seq #(
        .DIV_W (8)
    ) u_seq (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .start (seq_start),
        .up    (SWITCH_UPWARD),
        .cfg   (seq_cfg),
        .out   (seq_out)
    );

    // ========================================================
    // register file and state
    always_comb
    begin
        next_s       = s;
        next_s.rdata = '0;
        next_s.ready = CLOCK_STABLE;                                       // R12 R13
        if (!s.loaded)
        begin
            // configuration straps taken once after reset release
            next_s.loaded    = 1'b1;
            next_s.pend_cfg  = CFG_SLEW;                                   // R10
            next_s.act_cfg   = CFG_SLEW;
            next_s.pend_pdiv = CFG_PERIPH_DIV;
            next_s.act_pdiv  = CFG_PERIPH_DIV;
        end
        else
        begin
            if (WR && SYS_UNLOCKED)                                        // R9
            begin
                if (hit(ADDR, SLEW_CTRL_OFS))
                begin
                    next_s.pend_cfg  = slew_fields(WDATA);
                    next_s.pend_pdiv = WDATA[PDIV_LSB +: PDIV_W];          // R11
                end
                else if (hit(ADDR, STOP_DIAG_OFS))
                begin
                    next_s.stop = WDATA[STOP_W-1:0];                       // R14 R15
                end
            end
            if (OSC_SWITCH_REQUEST)
            begin
                next_s.act_cfg  = s.pend_cfg;                              // R8
                next_s.act_pdiv = s.pend_pdiv;
            end
        end
        if (RD)
        begin
            if (hit(ADDR, SLEW_CTRL_OFS))
            begin
                next_s.rdata = slew_word(s.pend_cfg, s.pend_pdiv, seq_out.busy);
            end
            else if (hit(ADDR, READY_STAT_OFS))
            begin
                next_s.rdata = {{(CSD_DATA_W-READY_W){1'b0}}, s.ready};     // R16
            end
            else if (hit(ADDR, STOP_DIAG_OFS))
            begin
                next_s.rdata = {{(CSD_DATA_W-STOP_W){1'b0}}, s.stop};
            end
            else
            begin
                next_s.rdata = '0;                                         // R16
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            s <= '{pend_cfg: '0, act_cfg: '0, pend_pdiv: '0, act_pdiv: '0,
                   ready: '0, stop: STOP_RESET, rdata: '0, loaded: 1'b0}; // R15
        end
        else
        begin
            s <= next_s;
        end
    end

    // ========================================================
    // outputs
    assign RDATA          = s.rdata;
    assign SOURCE_STOP    = s.stop;                                        // R14
    assign PERIPH_DIVISOR = s.act_pdiv;
    assign SLEW_DIVISOR   = seq_out.div;
    assign SLEW_BUSY      = seq_out.busy;
    assign SLEW_STEP_TICK = seq_out.tick;

    // ========================================================
    // checks
    AST_LOCKED_WRITE: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R9
        WR && !SYS_UNLOCKED && s.loaded |=> $stable(SOURCE_STOP) && $stable(s.pend_cfg))
        else $error("register changed by a write while locked");
    AST_STOP_WRITE: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R14
        WR && SYS_UNLOCKED && s.loaded && ADDR == ADDR_W'(STOP_DIAG_OFS)
        |=> SOURCE_STOP == $past(WDATA[STOP_W-1:0]))
        else $error("stop controls did not take the written value");
    AST_READY_FOLLOWS: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R12
        RD && ADDR == ADDR_W'(READY_STAT_OFS)
        |=> RDATA == {{(CSD_DATA_W-READY_W){1'b0}}, $past(CLOCK_STABLE, 2)})
        else $error("ready status not reporting clock stability");
    AST_SLEW_RESERVED_ZERO: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R16
        RD && ADDR == ADDR_W'(SLEW_CTRL_OFS) |=> RDATA[7:3] == 5'h00 && RDATA[31:28] == 4'h0)
        else $error("reserved slew control bits read nonzero");
    AST_PDIV_HELD: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R8
        s.loaded && !OSC_SWITCH_REQUEST |=> $stable(PERIPH_DIVISOR))
        else $error("divisor setting applied without a switch request");
    AST_PDIV_APPLY: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R8
        s.loaded && OSC_SWITCH_REQUEST |=> PERIPH_DIVISOR == $past(s.pend_pdiv))
        else $error("switch request did not apply the pending divisor");
    AST_STRAP_LOAD: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R10
        !s.loaded |=> s.pend_cfg == $past(CFG_SLEW) && PERIPH_DIVISOR == $past(CFG_PERIPH_DIV))
        else $error("reset configuration not loaded");
    AST_BUSY_READ: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R7
        RD && ADDR == ADDR_W'(SLEW_CTRL_OFS) |=> RDATA[BUSY_BIT] == $past(SLEW_BUSY))
        else $error("busy bit does not show the slew state");
    AST_UNMAPPED_ZERO: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R16
        RD && ADDR != ADDR_W'(SLEW_CTRL_OFS) && ADDR != ADDR_W'(READY_STAT_OFS)
        && ADDR != ADDR_W'(STOP_DIAG_OFS) |=> RDATA == '0)
        else $error("unmapped read returned data");
    AST_RDATA_ONLY_AFTER_READ: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R16
        !RD |=> RDATA == '0)
        else $error("read data stood outside the answer cycle");

endmodule

`default_nettype wire

// [tb/test_clock_slew_status_diag.sv]
// self-checking bench for the clock slew, ready status and stop diagnostic block
// assumes csd_pkg and csd_top are compiled first; assertions live in the design
`timescale 1ns/10ps
`default_nettype none

module test_clock_slew_status_diag;
    import csd_pkg::*;

    // ========================================================
    // stimulus and design
    logic                  SYS_CLK;
    logic                  RST_N;
    logic [CSD_ADDR_W-1:0] ADDR;
    logic [CSD_DATA_W-1:0] WDATA;
    logic                  WR;
    logic                  RD;
    logic [CSD_DATA_W-1:0] RDATA;
    logic                  SYS_UNLOCKED;
    logic                  OSC_SWITCH_REQUEST;
    logic                  SWITCH_UPWARD;
    csd_slew_cfg_s         CFG_SLEW;
    logic [PDIV_W-1:0]     CFG_PERIPH_DIV;
    logic [READY_W-1:0]    CLOCK_STABLE;
    logic [STOP_W-1:0]     SOURCE_STOP;
    logic [PDIV_W-1:0]     PERIPH_DIVISOR;
    logic [7:0]            SLEW_DIVISOR;
    logic                  SLEW_BUSY;
    logic                  SLEW_STEP_TICK;
    int                    n_errors;
    int                    compares;
    logic [31:0]           rv;
    int                    k;

    csd_top dut
    (
        .SYS_CLK            (SYS_CLK),
        .RST_N              (RST_N),
        .ADDR               (ADDR),
        .WDATA              (WDATA),
        .WR                 (WR),
        .RD                 (RD),
        .RDATA              (RDATA),
        .SYS_UNLOCKED       (SYS_UNLOCKED),
        .OSC_SWITCH_REQUEST (OSC_SWITCH_REQUEST),
        .SWITCH_UPWARD      (SWITCH_UPWARD),
        .CFG_SLEW           (CFG_SLEW),
        .CFG_PERIPH_DIV     (CFG_PERIPH_DIV),
        .CLOCK_STABLE       (CLOCK_STABLE),
        .SOURCE_STOP        (SOURCE_STOP),
        .PERIPH_DIVISOR     (PERIPH_DIVISOR),
        .SLEW_DIVISOR       (SLEW_DIVISOR),
        .SLEW_BUSY          (SLEW_BUSY),
        .SLEW_STEP_TICK     (SLEW_STEP_TICK)
    );

    always #4 SYS_CLK = ~SYS_CLK;

    // ========================================================
    // helpers
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge SYS_CLK);
        WR    <= 1'b0;
        @(negedge SYS_CLK);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge SYS_CLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge SYS_CLK);
        RD   <= 1'b0;
        @(negedge SYS_CLK);
        d = RDATA;
    endtask

    function automatic logic [31:0] slew_word(input logic [3:0] sc, input logic [3:0] pd,
                                              input logic [2:0] d, input logic up,
                                              input logic dn);
        return {4'h0, sc, 4'h0, pd, 5'h00, d, 5'h00, up, dn, 1'b0};
    endfunction

    // one switch; nst is the number of divisor steps expected (0 for none)
    task automatic sw_run(input logic up, input int sc, input int d, input int nst,
                          input logic [3:0] pd);
        int n;
        int ticks;
        int bad;
        int step;
        logic [7:0] ediv;
        n = 0;
        ticks = 0;
        bad = 0;
        @(posedge SYS_CLK);
        OSC_SWITCH_REQUEST <= 1'b1;
        SWITCH_UPWARD      <= up;
        @(posedge SYS_CLK);
        OSC_SWITCH_REQUEST <= 1'b0;
        @(negedge SYS_CLK);
        chk("periph divisor", {28'h0, pd}, {28'h0, PERIPH_DIVISOR});
        while (n < 2000)
        begin
            if (SLEW_STEP_TICK === 1'b1)
                ticks++;
            if (SLEW_BUSY !== 1'b1)
                break;
            step = n / (4 * (sc + 1));
            ediv = up ? 8'(1 << (d - step)) : 8'(2 << step);
            if (SLEW_DIVISOR !== ediv)
                bad++;
            n++;
            @(negedge SYS_CLK);
        end
        chk("busy cycles", 32'(nst * 4 * (sc + 1)), 32'(n));
        chk("step ticks", 32'(nst * (sc + 1)), 32'(ticks));
        chk("divisor walk errors", 32'h0, 32'(bad));
        chk("final divisor", 32'h1, {24'h0, SLEW_DIVISOR});
    endtask

    task automatic give_verdict;
        $display("comparisons %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ========================================================
    // watchdog
    initial
    begin
        #(8 * 20000);
        n_errors++;
        give_verdict();
    end

    // ========================================================
    // tests
    initial
    begin
        SYS_CLK = 1'b0;
        RST_N = 1'b0;
        ADDR = 8'h00;
        WDATA = 32'h0;
        WR = 1'b0;
        RD = 1'b0;
        SYS_UNLOCKED = 1'b0;
        OSC_SWITCH_REQUEST = 1'b0;
        SWITCH_UPWARD = 1'b0;
        CFG_SLEW = '{step_cnt: 4'h2, depth: 3'h3, up_en: 1'b1, dn_en: 1'b0};
        CFG_PERIPH_DIV = 4'hA;
        CLOCK_STABLE = 12'h000;
        n_errors = 0;
        compares = 0;
        repeat (16) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        repeat (2) @(posedge SYS_CLK);
        // reset values come from the straps
        rd(SLEW_CTRL_OFS, rv);
        chk("slew reset", slew_word(4'h2, 4'hA, 3'h3, 1'b1, 1'b0), rv);
        chk("periph reset", 32'hA, {28'h0, PERIPH_DIVISOR});
        rd(STOP_DIAG_OFS, rv);
        chk("stop reset", 32'h0, rv);
        // strap settings slew upward
        sw_run(1'b1, 2, 3, 3, 4'hA);
        sw_run(1'b0, 2, 3, 0, 4'hA);
        // locked writes are refused
        wr(SLEW_CTRL_OFS, 32'hFFFFFFFF);
        wr(STOP_DIAG_OFS, 32'h0000007F);
        rd(SLEW_CTRL_OFS, rv);
        chk("locked slew", slew_word(4'h2, 4'hA, 3'h3, 1'b1, 1'b0), rv);
        rd(STOP_DIAG_OFS, rv);
        chk("locked stop", 32'h0, rv);
        @(posedge SYS_CLK);
        SYS_UNLOCKED <= 1'b1;
        // each stop bit, then all ones with unimplemented bits
        for (k = 0; k < STOP_W; k++)
        begin
            wr(STOP_DIAG_OFS, 32'h1 << k);
            rd(STOP_DIAG_OFS, rv);
            chk("stop bit", 32'h1 << k, rv);
            chk("stop pin", 32'h1 << k, {25'h0, SOURCE_STOP});
        end
        wr(STOP_DIAG_OFS, 32'hFFFFFFFF);
        rd(STOP_DIAG_OFS, rv);
        chk("stop mask", 32'h7F, rv);
        wr(STOP_DIAG_OFS, 32'h0);
        chk("stop cleared", 32'h0, {25'h0, SOURCE_STOP});
        // ready bits follow the stable inputs, writes ignored
        for (k = 0; k < READY_W; k++)
        begin
            @(posedge SYS_CLK);
            CLOCK_STABLE <= 12'(1 << k);
            rd(READY_STAT_OFS, rv);
            chk("ready bit", 32'h1 << k, rv);
        end
        wr(READY_STAT_OFS, 32'h0);
        rd(READY_STAT_OFS, rv);
        chk("ready ro", 32'h800, rv);
        @(posedge SYS_CLK);
        CLOCK_STABLE <= 12'h000;
        rd(READY_STAT_OFS, rv);
        chk("ready cleared", 32'h0, rv);
        rd(8'h0C, rv);
        chk("unmapped read", 32'h0, rv);
        // all ones to slew control reads back implemented bits only
        wr(SLEW_CTRL_OFS, 32'hFFFFFFFF);
        rd(SLEW_CTRL_OFS, rv);
        chk("slew mask", 32'h0F0F0706, rv);
        // pending settings wait for the switch request
        wr(SLEW_CTRL_OFS, slew_word(4'h0, 4'h5, 3'h1, 1'b1, 1'b1));
        chk("periph pending", 32'hA, {28'h0, PERIPH_DIVISOR});
        sw_run(1'b1, 0, 1, 1, 4'h5);
        sw_run(1'b0, 0, 1, 1, 4'h5);
        wr(SLEW_CTRL_OFS, slew_word(4'hF, 4'h5, 3'h1, 1'b1, 1'b1));
        sw_run(1'b1, 15, 1, 1, 4'h5);
        wr(SLEW_CTRL_OFS, slew_word(4'h1, 4'h3, 3'h7, 1'b1, 1'b1));
        sw_run(1'b1, 1, 7, 7, 4'h3);
        wr(SLEW_CTRL_OFS, slew_word(4'h0, 4'h3, 3'h4, 1'b0, 1'b1));
        sw_run(1'b0, 0, 4, 4, 4'h3);
        sw_run(1'b1, 0, 4, 0, 4'h3);
        wr(SLEW_CTRL_OFS, slew_word(4'h0, 4'h3, 3'h0, 1'b1, 1'b1));
        sw_run(1'b1, 0, 0, 0, 4'h3);
        sw_run(1'b0, 0, 0, 0, 4'h3);
        // busy bit seen through the register while slewing
        wr(SLEW_CTRL_OFS, slew_word(4'hF, 4'h3, 3'h2, 1'b1, 1'b1));
        @(posedge SYS_CLK);
        OSC_SWITCH_REQUEST <= 1'b1;
        SWITCH_UPWARD      <= 1'b1;
        @(posedge SYS_CLK);
        OSC_SWITCH_REQUEST <= 1'b0;
        rd(SLEW_CTRL_OFS, rv);
        chk("busy bit set", slew_word(4'hF, 4'h3, 3'h2, 1'b1, 1'b1) | 32'h1, rv);
        repeat (140) @(posedge SYS_CLK);
        rd(SLEW_CTRL_OFS, rv);
        chk("busy bit clear", slew_word(4'hF, 4'h3, 3'h2, 1'b1, 1'b1), rv);
        give_verdict();
    end

endmodule

`default_nettype wire
